//--- core/rwmc_dev_end.sv
// device end: window steering, serial timer and mode control registers
`timescale 1ns/10ps
`default_nettype none
`include "rwmc_defs.svh"
module rwmc_dev_end
    import rwmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    rwmc_bus_if.dev bus,
    input wire logic [1:0] mode_pin,
    input wire logic [15:0] port12_dir,
    input wire logic [7:0] periph_rdata,
    output logic sel_serial_b,
    output logic sel_serial_c,
    output logic sel_twowire_b,
    output logic sel_twowire_a,
    output logic sel_pwconv,
    output logic sel_disp_sw,
    output logic sel_pwr_ctl,
    output logic sel_flash_ctl,
    output logic sel_reserved,
    output logic [1:0] twowire_rate_sel,
    output logic [1:0] timer_clk_sel,
    output logic [2:0] op_mode,
    output logic advanced_mode,
    output logic rom_enable,
    output logic emul_support,
    output logic ext_bus_on,
    output logic [15:0] port12_addr_oe,
    output logic port3_data_bus,
    output logic port4_bus_ctl,
    output logic [15:0] rom_limit_kb,
    output logic [15:0] ram_limit_kb,
    output logic shared_strobe_pin_n
);
    logic [1:0] mode_s1_q;
    logic [1:0] mode_s2_q;
    logic [1:0] settle_q;
    rwmc_mode_t mode_q;
    logic [7:0] serial_timer_control_q;
    logic expansion_enable_q;
    logic strobe_select_q;
    logic [7:0] rdata_q;
    logic ack_q;
    logic acc;
    logic bus_win;
    logic flash_win;
    logic expansion_enable;
    logic sel_any;
    logic onchip;
    logic [15:0] a16;

    function automatic logic in_rng(input logic [23:0] a,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    function automatic rwmc_mode_t pins_to_mode(input logic [1:0] p);
        case (p)
            2'h1: pins_to_mode = RWMC_MODE1;
            2'h2: pins_to_mode = RWMC_MODE2;
            default: pins_to_mode = RWMC_MODE3;
        endcase
    endfunction

    // ***************************************************************
    // mode pins: synchronised, then sampled for three cycles after reset release
    // ***************************************************************
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_s1_q <= 2'h0;
            mode_s2_q <= 2'h0;
        end
        else
        begin
            mode_s1_q <= mode_pin;
            mode_s2_q <= mode_s1_q;
        end
    end

    // pins are straps: sampled for three cycles after reset, then held so a glitch later cannot remap memory
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            settle_q <= 2'h0;
            mode_q <= RWMC_MODE3;
        end
        else if (settle_q != `RWMC_MODE_SETTLE)
        begin
            settle_q <= settle_q + 2'h1;
            mode_q <= pins_to_mode(mode_s2_q);
        end
    end

    // ***************************************************************
    // register writes
    // ***************************************************************
    assign acc = bus.rd || bus.wr;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serial_timer_control_q <= `RWMC_STC_RESET;
            expansion_enable_q <= 1'b0;
            strobe_select_q <= 1'b0;
        end
        else if (bus.wr)
        begin
            if (bus.addr == `RWMC_STC_ADDR)
            begin
                serial_timer_control_q <= bus.wdata;
            end
            else if (bus.addr == `RWMC_MDC_ADDR)
            begin
                expansion_enable_q <= bus.wdata[`RWMC_MDC_EXPANSION_ENABLE];
            end
            else if (bus.addr == `RWMC_SYC_ADDR)
            begin
                strobe_select_q <= bus.wdata[`RWMC_SYC_STROBE_SEL];
            end
        end
    end

    // writes land at the access edge, so the next access sees new steering
    assign bus_win = serial_timer_control_q[`RWMC_STC_BUS_WIN];
    assign flash_win = serial_timer_control_q[`RWMC_STC_FLASH_WIN];
    assign expansion_enable = (mode_q == RWMC_MODE1) || expansion_enable_q;
    assign bus.bus_win = bus_win;

    assign twowire_rate_sel =
        {serial_timer_control_q[`RWMC_STC_RATE_HI],
         serial_timer_control_q[`RWMC_STC_RATE_LO]};
    assign timer_clk_sel =
        {serial_timer_control_q[`RWMC_STC_TCLK_HI],
         serial_timer_control_q[`RWMC_STC_TCLK_LO]};

    // ***************************************************************
    // window steering
    // ***************************************************************
    logic win_ab;
    logic win_cd;
    logic win_ef;

    always_comb
    begin
        win_ab = in_rng(bus.addr, `RWMC_WIN_A_LO, `RWMC_WIN_A_HI) ||
                 in_rng(bus.addr, `RWMC_WIN_B_LO, `RWMC_WIN_B_HI);
        win_cd = in_rng(bus.addr, `RWMC_WIN_C_LO, `RWMC_WIN_C_HI) ||
                 in_rng(bus.addr, `RWMC_WIN_D_LO, `RWMC_WIN_D_HI);
        win_ef = in_rng(bus.addr, `RWMC_WIN_E_LO, `RWMC_WIN_E_HI) ||
                 in_rng(bus.addr, `RWMC_WIN_F_LO, `RWMC_WIN_F_HI);
    end

    assign sel_serial_b = acc && win_ab && !bus_win;
    assign sel_serial_c = acc && win_cd && !bus_win;
    assign sel_twowire_b = acc && win_ab && bus_win;
    assign sel_pwconv = acc && win_cd && bus_win;
    assign sel_twowire_a = acc && win_ef && bus_win;
    assign sel_disp_sw = acc && bus_win &&
        (bus.addr == `RWMC_DISP_SW_ADDR);
    assign sel_pwr_ctl = acc && !flash_win &&
        in_rng(bus.addr, `RWMC_PWR_LO, `RWMC_PWR_HI);
    assign sel_flash_ctl = acc && flash_win &&
        in_rng(bus.addr, `RWMC_FLASH_LO, `RWMC_FLASH_HI);

    // reserved areas answer zero and reach no peripheral
    assign sel_reserved = acc &&
        ((win_ef && !bus_win) ||
         (flash_win && in_rng(bus.addr, `RWMC_PWR_LO, `RWMC_PWR_HI)) ||
         (!flash_win &&
          in_rng(bus.addr, `RWMC_FLASH_LO, `RWMC_FLASH_HI)));

    assign sel_any = sel_serial_b || sel_serial_c || sel_twowire_b ||
        sel_twowire_a || sel_pwconv || sel_disp_sw || sel_pwr_ctl ||
        sel_flash_ctl;

    // ***************************************************************
    // read data and acknowledge
    // ***************************************************************
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= acc;
            if (bus.rd)
            begin
                if (bus.addr == `RWMC_STC_ADDR)
                begin
                    rdata_q <= serial_timer_control_q;
                end
                else if (bus.addr == `RWMC_MDC_ADDR)
                begin
                    rdata_q <= {expansion_enable, 5'h00, mode_s2_q};
                end
                else if (bus.addr == `RWMC_SYC_ADDR)
                begin
                    rdata_q <= {1'b0, strobe_select_q, 6'h00};
                end
                else if (sel_any)
                begin
                    rdata_q <= periph_rdata;
                end
                else
                begin
                    rdata_q <= 8'h00;
                end
            end
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.ack = ack_q;

    // ***************************************************************
    // operating mode outputs
    // ***************************************************************
    assign op_mode = mode_q;
    assign advanced_mode = (mode_q != RWMC_MODE3);
    assign rom_enable = (mode_q != RWMC_MODE1);
    assign emul_support = (mode_q != RWMC_MODE1);
    assign ext_bus_on = expansion_enable;
    assign port12_addr_oe = (mode_q == RWMC_MODE1) ? 16'hffff :
        (expansion_enable ? port12_dir : 16'h0000);
    assign port3_data_bus = expansion_enable;
    assign port4_bus_ctl = expansion_enable;
    assign rom_limit_kb = (mode_q == RWMC_MODE3) ? 16'h0038 : 16'h0000;
    assign ram_limit_kb = (mode_q == RWMC_MODE3) ? 16'h0004 : 16'h0000;
    // mode 3 caps, output only; the on-chip decode below does not use them

    // ***************************************************************
    // shared strobe
    // ***************************************************************
    assign a16 = bus.addr[15:0];

    always_comb
    begin
        if (mode_q == RWMC_MODE3)
        begin
            onchip = (a16 < `RWMC_NRM_ROM_TOP) ||
                (a16 < `RWMC_NRM_RAM_TOP) ||
                (a16 >= `RWMC_NRM_IO_LO);
        end
        else
        begin
            onchip = (rom_enable && (bus.addr < `RWMC_ADV_ROM_TOP)) ||
                (bus.addr >= `RWMC_ADV_RAM_LO &&
                 bus.addr < `RWMC_ADV_IO_LO + 24'h000800 -
                 24'h001000) ||
                (bus.addr >= `RWMC_ADV_IO_LO);
        end
    end

    // only 16 address lines leave the chip, hence the i/o strobe window
    always_comb
    begin
        shared_strobe_pin_n = 1'b1;
        if (acc && expansion_enable && !onchip)
        begin
            if (!strobe_select_q)
            begin
                shared_strobe_pin_n = 1'b0;
            end
            else if (a16 >= `RWMC_IOS_LO && a16 <= `RWMC_IOS_HI &&
                     (mode_q == RWMC_MODE3 ||
                      bus.addr[23:16] == 8'hff))
            begin
                shared_strobe_pin_n = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- core/rwmc_defs.svh
// address, field and reset constants of the register window and mode block
`ifndef RWMC_DEFS_SVH
`define RWMC_DEFS_SVH

// ***************************************************************
// own registers on the internal bus
// ***************************************************************
`define RWMC_STC_ADDR 24'hfffff0
`define RWMC_MDC_ADDR 24'hfffff1
`define RWMC_SYC_ADDR 24'hfffff2
`define RWMC_STC_RESET 8'h00
`define RWMC_SYC_RESET 8'h00

// ***************************************************************
// field positions
// ***************************************************************
`define RWMC_STC_RSV_HI 7
`define RWMC_STC_RATE_HI 6
`define RWMC_STC_RATE_LO 5
`define RWMC_STC_BUS_WIN 4
`define RWMC_STC_FLASH_WIN 3
`define RWMC_STC_RSV_LO 2
`define RWMC_STC_TCLK_HI 1
`define RWMC_STC_TCLK_LO 0
`define RWMC_MDC_EXPANSION_ENABLE 7
`define RWMC_SYC_STROBE_SEL 6

// ***************************************************************
// steered windows (first and last byte)
// ***************************************************************
`define RWMC_WIN_A_LO 24'hffff88
`define RWMC_WIN_A_HI 24'hffff89
`define RWMC_WIN_B_LO 24'hffff8e
`define RWMC_WIN_B_HI 24'hffff8f
`define RWMC_WIN_C_LO 24'hffffa0
`define RWMC_WIN_C_HI 24'hffffa1
`define RWMC_WIN_D_LO 24'hffffa6
`define RWMC_WIN_D_HI 24'hffffa7
`define RWMC_WIN_E_LO 24'hffffd8
`define RWMC_WIN_E_HI 24'hffffd9
`define RWMC_WIN_F_LO 24'hffffde
`define RWMC_WIN_F_HI 24'hffffdf
`define RWMC_DISP_SW_ADDR 24'hfffee6
`define RWMC_PWR_LO 24'hffff80
`define RWMC_PWR_HI 24'hffff87
`define RWMC_FLASH_LO 24'hfffea8
`define RWMC_FLASH_HI 24'hfffeae

// ***************************************************************
// memory layout per mode
// ***************************************************************
`define RWMC_IOS_LO 16'hf000
`define RWMC_IOS_HI 16'hf7ff
`define RWMC_ADV_ROM_TOP 24'h020000
`define RWMC_ADV_RAM_LO 24'hffe000
`define RWMC_ADV_IO_LO 24'hfff800
`define RWMC_NRM_ROM_TOP 16'he000
`define RWMC_NRM_RAM_TOP 16'hf000
`define RWMC_NRM_IO_LO 16'hf800
`define RWMC_MODE_SETTLE 2'h3

`endif

//--- core/rwmc_pkg.sv
// types shared by both ends of the register window and mode block
package rwmc_pkg;
    typedef enum logic [2:0]
    {
        RWMC_MODE1 = 3'b001,
        RWMC_MODE2 = 3'b010,
        RWMC_MODE3 = 3'b100
    } rwmc_mode_t;
endpackage

//--- core/rwmc_bus_if.sv
// internal bus between the cpu end and the register window block
`timescale 1ns/10ps
`default_nettype none
interface rwmc_bus_if;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
    logic [7:0] rdata;
    logic ack;
    logic bus_win;
    modport dev
    (
        input addr, wdata, rd, wr,
        output rdata, ack, bus_win
    );
    modport cpu
    (
        output addr, wdata, rd, wr,
        input rdata, ack, bus_win
    );
endinterface
`default_nettype wire

//--- core/rwmc_cpu_end.sv
// cpu end: turns user requests into single bus cycles
`timescale 1ns/10ps
`default_nettype none
`include "rwmc_defs.svh"
module rwmc_cpu_end
    import rwmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    rwmc_bus_if.cpu bus,
    input wire logic req_rd,
    input wire logic req_wr,
    input wire logic [23:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic req_refused
);
    logic busy_q;
    logic rd_q;
    logic wr_q;
    logic [23:0] addr_q;
    logic [7:0] wdata_q;
    logic resp_valid_q;
    logic [7:0] resp_data_q;
    logic refused_q;
    logic go;
    logic blocked;

    // ***************************************************************
    // guard against the prohibited windows
    // ***************************************************************
    function automatic logic in_rng(input logic [23:0] a,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // with serial ports mapped, the third pair of windows is off limits
    always_comb
    begin
        blocked = !bus.bus_win &&
            (in_rng(req_addr, `RWMC_WIN_E_LO, `RWMC_WIN_E_HI) ||
             in_rng(req_addr, `RWMC_WIN_F_LO, `RWMC_WIN_F_HI));
    end

    assign req_ready = !busy_q;
    assign go = (req_rd || req_wr) && !busy_q;

    // ***************************************************************
    // bus cycle
    // ***************************************************************
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 24'h000000;
            wdata_q <= 8'h00;
        end
        else
        begin
            rd_q <= go && !blocked && req_rd;
            wr_q <= go && !blocked && !req_rd && req_wr;
            if (go && !blocked)
            begin
                busy_q <= 1'b1;
                addr_q <= req_addr;
                wdata_q <= req_wdata;
            end
            else if (bus.ack)
            begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            resp_valid_q <= 1'b0;
            resp_data_q <= 8'h00;
            refused_q <= 1'b0;
        end
        else
        begin
            resp_valid_q <= bus.ack;
            refused_q <= go && blocked;
            if (bus.ack)
            begin
                resp_data_q <= bus.rdata;
            end
        end
    end

    assign bus.rd = rd_q;
    assign bus.wr = wr_q;
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign resp_valid = resp_valid_q;
    assign resp_data = resp_data_q;
    assign req_refused = refused_q;
endmodule
`default_nettype wire

//--- bench/rwmc_monitor.sv
// concurrent checks on the internal bus of the register window block
`timescale 1ns/10ps
`default_nettype none
`include "rwmc_defs.svh"
module rwmc_monitor
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [23:0] addr,
    input wire logic [7:0] wdata,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] rdata,
    input wire logic ack,
    input wire logic bus_win
);
    logic [7:0] stc_q;
    logic stc_hit;
    logic in_flash;
    logic in_pwr;
    logic in_shut;
    assign stc_hit = addr == `RWMC_STC_ADDR;
    assign in_flash = addr >= `RWMC_FLASH_LO && addr <= `RWMC_FLASH_HI;
    assign in_pwr = addr >= `RWMC_PWR_LO && addr <= `RWMC_PWR_HI;
    assign in_shut = (addr >= `RWMC_WIN_E_LO && addr <= `RWMC_WIN_E_HI)
        || (addr >= `RWMC_WIN_F_LO && addr <= `RWMC_WIN_F_HI);
    // own copy of the register, so read data is judged independently
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            stc_q <= 8'h00;
        else if (wr && stc_hit)
            stc_q <= wdata;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    // ***********************************************************
    // bus checks
    // ***********************************************************
    property p_ack; (rd || wr) |=> ack ##1 !ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack pulse");
    property p_ack_cause; ack |-> $past(rd || wr); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_win_set;
        (wr && stc_hit) |=> bus_win == $past(wdata[`RWMC_STC_BUS_WIN]);
    endproperty
    a_win_set: assert property (p_win_set) else $error("win bit");
    property p_win_hold; !(wr && stc_hit) |=> $stable(bus_win); endproperty
    a_win_hold: assert property (p_win_hold) else $error("win moved");
    property p_stc_read; (rd && stc_hit) |=> ack && rdata == stc_q; endproperty
    a_stc_read: assert property (p_stc_read) else $error("stc data");
    property p_flash_rsv;
        (rd && in_flash && !stc_q[3]) |=> rdata == 8'h00;
    endproperty
    a_flash_rsv: assert property (p_flash_rsv) else $error("rsv data");
    property p_pwr_rsv; (rd && in_pwr && stc_q[3]) |=> rdata == 8'h00; endproperty
    a_pwr_rsv: assert property (p_pwr_rsv) else $error("rsv data");
    property p_shut; ((rd || wr) && !bus_win) |-> !in_shut; endproperty
    a_shut: assert property (p_shut) else $error("shut window hit");
    property p_rst; $rose(nrst) |-> !bus_win && !ack; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule
`default_nettype wire

//--- bench/rwmc_bench.sv
// self-checking bench joining the cpu end and the device end
`timescale 1ns/10ps
`default_nettype none
`include "rwmc_defs.svh"
module rwmc_bench
    import rwmc_pkg::*;
;
    logic core_clk;
    logic nrst = 1'b0;
    logic req_rd = 1'b0;
    logic req_wr = 1'b0;
    logic [23:0] req_addr = 24'h000000;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready;
    logic resp_valid;
    logic [7:0] resp_data;
    logic req_refused;
    logic [1:0] mode_pin = 2'h3;
    logic [15:0] port12_dir = 16'h5a3c;
    logic [7:0] periph_rdata = 8'ha5;
    wire logic [8:0] sel;
    wire logic [5:0] flags;
    logic [1:0] twowire_rate_sel;
    logic [1:0] timer_clk_sel;
    logic [2:0] op_mode;
    logic [15:0] port12_addr_oe;
    logic [15:0] rom_limit_kb;
    logic [15:0] ram_limit_kb;
    logic shared_strobe_pin_n;
    logic [8:0] sel_seen;
    logic strobe_seen;
    logic last_refused;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    rwmc_bus_if rwmc_bus_if_i ();
    rwmc_cpu_end rwmc_cpu_end_i
    (
        .core_clk, .nrst, .bus(rwmc_bus_if_i.cpu), .req_rd, .req_wr,
        .req_addr, .req_wdata, .req_ready, .resp_valid, .resp_data,
        .req_refused
    );
    rwmc_dev_end rwmc_dev_end_i
    (
        .core_clk, .nrst, .bus(rwmc_bus_if_i.dev), .mode_pin, .port12_dir,
        .periph_rdata, .sel_serial_b(sel[8]), .sel_serial_c(sel[7]),
        .sel_twowire_b(sel[6]), .sel_twowire_a(sel[5]), .sel_pwconv(sel[4]),
        .sel_disp_sw(sel[3]), .sel_pwr_ctl(sel[2]), .sel_flash_ctl(sel[1]),
        .sel_reserved(sel[0]), .twowire_rate_sel, .timer_clk_sel, .op_mode,
        .advanced_mode(flags[5]), .rom_enable(flags[4]),
        .emul_support(flags[3]), .ext_bus_on(flags[2]),
        .port3_data_bus(flags[1]), .port4_bus_ctl(flags[0]),
        .port12_addr_oe, .rom_limit_kb, .ram_limit_kb, .shared_strobe_pin_n
    );
    rwmc_monitor rwmc_monitor_i
    (
        .core_clk, .nrst, .addr(rwmc_bus_if_i.addr),
        .wdata(rwmc_bus_if_i.wdata), .rd(rwmc_bus_if_i.rd),
        .wr(rwmc_bus_if_i.wr), .rdata(rwmc_bus_if_i.rdata),
        .ack(rwmc_bus_if_i.ack), .bus_win(rwmc_bus_if_i.bus_win)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // select lines only live in the bus cycle, so latch them mid-cycle
    always @(negedge core_clk)
    begin
        if (rwmc_bus_if_i.rd || rwmc_bus_if_i.wr)
        begin
            sel_seen = sel;
            strobe_seen = shared_strobe_pin_n;
        end
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            results();
        end
    end
    // ***********************************************************
    // tasks
    // ***********************************************************
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic access(input logic rd, input logic [23:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        sel_seen = 9'h000;
        strobe_seen = 1'b1;
        while (req_ready !== 1'b1 && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        req_rd = rd;
        req_wr = !rd;
        req_addr = a;
        req_wdata = d;
        @(negedge core_clk);
        req_rd = 1'b0;
        req_wr = 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && req_refused !== 1'b1 && n < 10)
        begin
            @(negedge core_clk);
            n++;
        end
        last_refused = req_refused;
        if (n == 10)
            check(32'h0, 32'h1);
        @(negedge core_clk);
    endtask
    task automatic rd_chk(input logic [23:0] a, input logic [7:0] exp);
        access(1'b1, a, 8'h00);
        check({24'h0, resp_data}, {24'h0, exp});
    endtask
    task automatic do_reset(input logic [1:0] m);
        @(negedge core_clk);
        nrst = 1'b0;
        mode_pin = m;
        repeat (6) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic chk_mode(input logic [8:0] f, input logic [15:0] oe,
        input logic [15:0] rl, input logic [15:0] ml);
        check({23'h0, op_mode, flags}, {23'h0, f});
        check({16'h0, port12_addr_oe}, {16'h0, oe});
        check({rom_limit_kb, ram_limit_kb}, {rl, ml});
    endtask
    task automatic stc_chk(input logic [7:0] d, input logic [3:0] f);
        access(1'b0, `RWMC_STC_ADDR, d);
        check({28'h0, twowire_rate_sel, timer_clk_sel}, {28'h0, f});
        rd_chk(`RWMC_STC_ADDR, d);
    endtask
    task automatic win(input logic [7:0] s, input logic [23:0] a,
        input logic [8:0] exp, input logic [7:0] d);
        access(1'b0, `RWMC_STC_ADDR, s);
        rd_chk(a, d);
        check({23'h0, sel_seen}, {23'h0, exp});
    endtask
    task automatic strb(input logic [7:0] s, input logic [23:0] a,
        input logic exp);
        access(1'b0, `RWMC_SYC_ADDR, s);
        access(1'b1, a, 8'h00);
        check({31'h0, strobe_seen}, {31'h0, exp});
    endtask
    // ***********************************************************
    // sequence
    // ***********************************************************
    initial
    begin
        do_reset(2'h3);
        chk_mode(9'h118, 16'h0000, 16'h0038, 16'h0004);
        rd_chk(`RWMC_STC_ADDR, 8'h00);
        rd_chk(`RWMC_MDC_ADDR, 8'h03);
        access(1'b0, `RWMC_MDC_ADDR, 8'h80);
        chk_mode(9'h11f, 16'h5a3c, 16'h0038, 16'h0004);
        do_reset(2'h1);
        chk_mode(9'h067, 16'hffff, 16'h0000, 16'h0000);
        access(1'b0, `RWMC_MDC_ADDR, 8'h00);
        rd_chk(`RWMC_MDC_ADDR, 8'h81);
        do_reset(2'h2);
        chk_mode(9'h0b8, 16'h0000, 16'h0000, 16'h0000);
        // reserved bits 7 and 2 are never written
        stc_chk(8'h63, 4'hf);
        stc_chk(8'h41, 4'h9);
        stc_chk(8'h22, 4'h6);
        win(8'h00, 24'hffff88, 9'h100, 8'ha5);
        win(8'h00, 24'hffff8f, 9'h100, 8'ha5);
        win(8'h00, 24'hffffa1, 9'h080, 8'ha5);
        win(8'h00, 24'hffffa6, 9'h080, 8'ha5);
        win(8'h10, 24'hffff89, 9'h040, 8'ha5);
        win(8'h10, 24'hffff8e, 9'h040, 8'ha5);
        win(8'h10, 24'hffffa0, 9'h010, 8'ha5);
        win(8'h10, 24'hffffa7, 9'h010, 8'ha5);
        win(8'h10, 24'hffffd8, 9'h020, 8'ha5);
        win(8'h10, 24'hffffdf, 9'h020, 8'ha5);
        win(8'h10, 24'hfffee6, 9'h008, 8'ha5);
        win(8'h00, 24'hffff80, 9'h004, 8'ha5);
        win(8'h00, 24'hffff87, 9'h004, 8'ha5);
        win(8'h00, 24'hfffea8, 9'h001, 8'h00);
        win(8'h08, 24'hfffeae, 9'h002, 8'ha5);
        win(8'h08, 24'hffff80, 9'h001, 8'h00);
        access(1'b0, 24'hffffde, 8'h5a);
        check({31'h0, last_refused}, 32'h1);
        check({23'h0, sel_seen}, 32'h0);
        access(1'b0, `RWMC_MDC_ADDR, 8'h80);
        chk_mode(9'h0bf, 16'h5a3c, 16'h0000, 16'h0000);
        strb(8'h00, 24'h030000, 1'b0);
        strb(8'h00, 24'hfff100, 1'b0);
        strb(8'h40, 24'h030000, 1'b1);
        strb(8'h40, 24'hfff000, 1'b0);
        strb(8'h40, 24'hfff7ff, 1'b0);
        do_reset(2'h2);
        rd_chk(`RWMC_STC_ADDR, 8'h00);
        results();
    end
endmodule
`default_nettype wire
